// *** pkg/cma_pkg.sv ***
package cma_pkg;

    // ************************************************************
    // widths and data-space map
    // ************************************************************
    localparam int          PC_W     = 13;
    localparam logic [15:0] IO_BASE  = 16'h0020;
    localparam logic [15:0] REGF_END = 16'h0020;
    localparam logic [15:0] IO_END   = 16'h0060;
    localparam logic [15:0] EXT_END  = 16'h0100;
    localparam logic [15:0] SRAM_END = 16'h0500;
    localparam logic [15:0] SP_RST   = 16'h04FF;

    // ************************************************************
    // eeprom access registers, inside standard i/o
    // ************************************************************
    localparam logic [15:0] EE_CTRL_A = 16'h003F;
    localparam logic [15:0] EE_DATA_A = 16'h0040;
    localparam logic [15:0] EE_ADRL_A = 16'h0041;
    localparam logic [15:0] EE_ADRH_A = 16'h0042;
    localparam int          EE_RD_BIT  = 0;
    localparam int          EE_WR_BIT  = 1;
    localparam int          EE_MWE_BIT = 2;
    localparam int          EE_BYTES   = 512;

    // ************************************************************
    // timing
    // ************************************************************
    localparam logic [3:0] IRQ_ENTRY_CYC = 4'h4;
    localparam logic [3:0] IRQ_JMP_CYC   = 4'h3;
    localparam logic [3:0] IRQ_WAKE_CYC  = 4'h4;
    localparam logic [3:0] RETURN_FROM_INTERRUPT_CYC      = 4'h4;
    localparam logic [3:0] EE_RD_STALL   = 4'h4;
    localparam logic [3:0] EE_WR_STALL   = 4'h2;
    localparam logic [2:0] MWE_WINDOW    = 3'h4;
    localparam int CLK_PERIOD_NS = 25;
    localparam int EE_WRITE_NS   = 3300000;
    localparam int EE_WRITE_CYC  = EE_WRITE_NS / CLK_PERIOD_NS;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [2:0] {
        M_DIRECT, M_DISP, M_IND, M_PREDEC, M_POSTINC, M_IOSHORT
    } cma_mode_t;

    typedef enum logic [2:0] {
        R_REGF, R_IO, R_EXT, R_SRAM, R_NONE
    } cma_region_t;

    typedef enum {
        S_IDLE, S_SRAM, S_STALL, S_WAKE, S_PUSH, S_JUMP, S_RETURN_FROM_INTERRUPT
    } cma_fsm_t;

    typedef struct packed {
        logic        wr;
        cma_mode_t   mode;
        logic [1:0]  ptr;
        logic [5:0]  disp;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } cma_acc_t;

    typedef struct packed {
        logic        we;
        logic        re;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } cma_stk_t;

    typedef struct packed {
        logic        en;
        logic [1:0]  sel;
        logic [15:0] val;
    } cma_ptrwb_t;

    typedef struct packed {
        cma_fsm_t    fsm;
        logic [3:0]  cnt;
        logic        gie;
        logic [15:0] sp;
        logic [12:0] pc_ret;
        logic [12:0] vec;
        logic [7:0]  pop_hi;
        logic        acc_done;
        cma_region_t region;
        logic [15:0] eaddr;
        logic [7:0]  rdata;
        logic        sram_ce;
        logic        sram_we;
        cma_ptrwb_t  ptr_wb;
        logic        stall;
        logic        pc_load;
        logic [12:0] pc_out;
        logic        irq_ack;
        cma_stk_t    stk;
        logic [8:0]  ee_addr;
        logic [7:0]  ee_data;
        logic        mwe;
        logic [2:0]  mwe_cnt;
        logic        ee_busy;
        logic [17:0] ee_tmr;
        logic        ee_go;
        logic        ee_rd;
    } cma_state_t;

    localparam cma_state_t STATE_RST = '{
        fsm: S_IDLE, region: R_REGF, sp: SP_RST, default: '0
    };

endpackage

// *** design/cma_core.sv ***
module cma_core #(
    parameter int EE_WRITE_CYCLES = cma_pkg::EE_WRITE_CYC
) (
    input  wire logic                 SYS_CLK,     // cpu clock
    input  wire logic                 RST_B,       // sync reset
    input  wire logic                 CE,          // clock enable
    input  wire logic                 ACC_REQ,     // data access
    input  wire cma_pkg::cma_acc_t    ACC_CMD,     // access command
    input  wire logic [47:0]          PTR_FILE,    // r26..r31
    input  wire logic                 RETURN_FROM_INTERRUPT_REQ,    // return request
    input  wire logic                 IRQ_REQ,     // pending irq
    input  wire logic [12:0]          IRQ_VEC,     // vector address
    input  wire logic                 INSN_BUSY,   // multi-cycle op
    input  wire logic                 SLEEPING,    // core asleep
    input  wire logic                 WAKE_READY,  // start-up over
    input  wire logic [12:0]          PC_IN,       // return pc
    input  wire logic [7:0]           STK_RDATA,   // stack read data
    input  wire logic                 GIE_SET,     // set enable
    input  wire logic                 GIE_CLR,     // clear enable
    output logic                      ACC_DONE,    // access done
    output cma_pkg::cma_region_t      ACC_REGION,  // decoded region
    output logic [15:0]               ACC_EADDR,   // effective addr
    output logic [7:0]                ACC_RDATA,   // eeprom reg data
    output logic                      SRAM_CE,     // sram select
    output logic                      SRAM_WE,     // sram write
    output cma_pkg::cma_ptrwb_t       PTR_WB,      // pointer update
    output logic                      CPU_STALL,   // hold the core
    output logic                      GIE,         // global enable
    output logic                      IRQ_ACK,     // irq accepted
    output logic                      PC_LOAD,     // load pc
    output logic [12:0]               PC_OUT,      // new pc
    output cma_pkg::cma_stk_t         STK,         // stack access
    output logic [15:0]               SP           // stack pointer
);

    // ************************************************************
    // state
    // ************************************************************
    cma_pkg::cma_state_t r;
    cma_pkg::cma_state_t n;
    logic [7:0]          ee_mem [cma_pkg::EE_BYTES];

    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            r <= cma_pkg::STATE_RST;
        end else if (CE) begin
            r <= n;
        end
    end

    // no reset on the array: contents survive like the real cells
    always_ff @(posedge SYS_CLK) begin
        if (CE && n.ee_go) begin
            ee_mem[r.ee_addr] <= r.ee_data;
        end
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        logic [15:0] ptr;
        logic [15:0] ea;
        logic [7:0]  ctl;
        ptr = 16'h0000;
        ea  = 16'h0000;
        ctl = 8'h00;
        n   = r;
        n.acc_done  = 1'b0;
        n.sram_ce   = 1'b0;
        n.irq_ack   = 1'b0;
        n.pc_load   = 1'b0;
        n.stk.we    = 1'b0;
        n.stk.re    = 1'b0;
        n.ptr_wb.en = 1'b0;
        n.ee_go     = 1'b0;
        n.ee_rd     = 1'b0;

        unique case (ACC_CMD.ptr)
            2'h0:    ptr = PTR_FILE[15:0];
            2'h1:    ptr = PTR_FILE[31:16];
            default: ptr = PTR_FILE[47:32];
        endcase
        unique case (ACC_CMD.mode)
            cma_pkg::M_DIRECT:  ea = ACC_CMD.addr;
            cma_pkg::M_DISP:    ea = ptr + {10'h000, ACC_CMD.disp};
            cma_pkg::M_IND:     ea = ptr;
            cma_pkg::M_PREDEC:  ea = ptr - 16'h0001;
            cma_pkg::M_POSTINC: ea = ptr;
            cma_pkg::M_IOSHORT: ea = cma_pkg::IO_BASE
                          + {10'h000, ACC_CMD.addr[5:0]};
            default:   ea = ACC_CMD.addr;
        endcase

        ctl[cma_pkg::EE_MWE_BIT] = r.mwe;
        ctl[cma_pkg::EE_WR_BIT]  = r.ee_busy;

        if (r.ee_busy) begin
            n.ee_tmr = r.ee_tmr - 18'h0_0001;
            if (r.ee_tmr == 18'h0_0001) begin
                n.ee_busy = 1'b0;
            end
        end
        if (r.mwe) begin
            n.mwe_cnt = r.mwe_cnt - 3'h1;
            if (r.mwe_cnt == 3'h1) begin
                n.mwe = 1'b0;
            end
        end
        if (GIE_SET) begin
            n.gie = 1'b1;
        end
        if (GIE_CLR) begin
            n.gie = 1'b0;
        end

        unique case (r.fsm)
            cma_pkg::S_IDLE: begin
                if (RETURN_FROM_INTERRUPT_REQ) begin
                    n.fsm = cma_pkg::S_RETURN_FROM_INTERRUPT;
                    n.cnt = 4'h0;
                end else if (ACC_REQ) begin
                    n.eaddr = ea;
                    if (ea < cma_pkg::REGF_END) begin
                        n.region = cma_pkg::R_REGF;
                    end else if (ea < cma_pkg::IO_END) begin
                        n.region = cma_pkg::R_IO;
                    end else if (ea < cma_pkg::EXT_END) begin
                        n.region = cma_pkg::R_EXT;
                    end else if (ea < cma_pkg::SRAM_END) begin
                        n.region = cma_pkg::R_SRAM;
                    end else begin
                        n.region = cma_pkg::R_NONE;
                    end
                    if (ACC_CMD.mode == cma_pkg::M_PREDEC
                        || ACC_CMD.mode == cma_pkg::M_POSTINC) begin
                        n.ptr_wb.en  = 1'b1;
                        n.ptr_wb.sel = ACC_CMD.ptr;
                        n.ptr_wb.val = (ACC_CMD.mode == cma_pkg::M_PREDEC)
                                     ? ea : ptr + 16'h0001;
                    end
                    if (n.region == cma_pkg::R_SRAM) begin
                        n.sram_ce = 1'b1;
                        n.sram_we = ACC_CMD.wr;
                        n.fsm     = cma_pkg::S_SRAM;
                    end else begin
                        n.acc_done = 1'b1;
                        n.rdata    = 8'h00;
                        if (!ACC_CMD.wr) begin
                            unique case (ea)
                                cma_pkg::EE_CTRL_A: n.rdata = ctl;
                                cma_pkg::EE_DATA_A: n.rdata = r.ee_data;
                                cma_pkg::EE_ADRL_A:
                                    n.rdata = r.ee_addr[7:0];
                                cma_pkg::EE_ADRH_A:
                                    n.rdata = {7'h00, r.ee_addr[8]};
                                default: n.rdata = 8'h00;
                            endcase
                        // address and data are frozen while writing
                        end else if (ea == cma_pkg::EE_CTRL_A) begin
                            if (ACC_CMD.wdata[cma_pkg::EE_MWE_BIT]
                                && !ACC_CMD.wdata[cma_pkg::EE_WR_BIT]
                                && !r.mwe) begin
                                n.mwe     = 1'b1;
                                n.mwe_cnt = cma_pkg::MWE_WINDOW;
                            end
                            if (ACC_CMD.wdata[cma_pkg::EE_WR_BIT]
                                && r.mwe && !r.ee_busy) begin
                                n.ee_go   = 1'b1;
                                n.ee_busy = 1'b1;
                                n.ee_tmr  = 18'(EE_WRITE_CYCLES);
                                n.fsm     = cma_pkg::S_STALL;
                                n.cnt     = cma_pkg::EE_WR_STALL;
                            end else if (
                                ACC_CMD.wdata[cma_pkg::EE_RD_BIT]
                                && !r.ee_busy) begin
                                n.ee_rd   = 1'b1;
                                n.ee_data = ee_mem[r.ee_addr];
                                n.fsm     = cma_pkg::S_STALL;
                                n.cnt     = cma_pkg::EE_RD_STALL;
                            end
                        end else if (!r.ee_busy) begin
                            if (ea == cma_pkg::EE_DATA_A) begin
                                n.ee_data = ACC_CMD.wdata;
                            end else if (ea == cma_pkg::EE_ADRL_A) begin
                                n.ee_addr[7:0] = ACC_CMD.wdata;
                            end else if (ea == cma_pkg::EE_ADRH_A) begin
                                n.ee_addr[8] = ACC_CMD.wdata[0];
                            end
                        end
                    end
                end else if (IRQ_REQ && r.gie && !INSN_BUSY) begin
                    n.gie     = 1'b0;
                    n.irq_ack = 1'b1;
                    n.pc_ret  = PC_IN;
                    n.vec     = IRQ_VEC;
                    n.cnt     = 4'h0;
                    n.fsm     = SLEEPING ? cma_pkg::S_WAKE : cma_pkg::S_PUSH;
                end
            end
            cma_pkg::S_SRAM: begin
                n.acc_done = 1'b1;
                n.fsm      = cma_pkg::S_IDLE;
            end
            cma_pkg::S_STALL: begin
                n.cnt = r.cnt - 4'h1;
                if (r.cnt == 4'h1) begin
                    n.fsm = cma_pkg::S_IDLE;
                end
            end
            cma_pkg::S_WAKE: begin
                // counting starts once the oscillator start-up is over
                if (WAKE_READY || r.cnt != 4'h0) begin
                    n.cnt = r.cnt + 4'h1;
                    if (r.cnt == cma_pkg::IRQ_WAKE_CYC - 4'h1) begin
                        n.fsm = cma_pkg::S_PUSH;
                        n.cnt = 4'h0;
                    end
                end
            end
            cma_pkg::S_PUSH: begin
                n.cnt = r.cnt + 4'h1;
                if (r.cnt < 4'h2) begin
                    n.stk.we    = 1'b1;
                    n.stk.addr  = r.sp;
                    n.stk.wdata = (r.cnt == 4'h0) ? r.pc_ret[7:0]
                                : {3'h0, r.pc_ret[12:8]};
                    n.sp        = r.sp - 16'h0001;
                end
                if (r.cnt == cma_pkg::IRQ_ENTRY_CYC - 4'h1) begin
                    n.pc_load = 1'b1;
                    n.pc_out  = r.vec;
                    n.fsm     = cma_pkg::S_JUMP;
                    n.cnt     = 4'h0;
                end
            end
            cma_pkg::S_JUMP: begin
                n.cnt = r.cnt + 4'h1;
                if (r.cnt == cma_pkg::IRQ_JMP_CYC - 4'h1) begin
                    n.fsm = cma_pkg::S_IDLE;
                end
            end
            cma_pkg::S_RETURN_FROM_INTERRUPT: begin
                n.cnt = r.cnt + 4'h1;
                if (r.cnt < 4'h2) begin
                    n.stk.re   = 1'b1;
                    n.stk.addr = r.sp + 16'h0001;
                    n.sp       = r.sp + 16'h0001;
                end
                if (r.cnt == 4'h2) begin
                    n.pop_hi = STK_RDATA;
                end
                if (r.cnt == cma_pkg::RETURN_FROM_INTERRUPT_CYC - 4'h1) begin
                    n.pc_load = 1'b1;
                    n.pc_out  = {r.pop_hi[4:0], STK_RDATA};
                    n.gie     = 1'b1;
                    n.fsm     = cma_pkg::S_IDLE;
                end
            end
        endcase
        n.stall = !(n.fsm inside {cma_pkg::S_IDLE, cma_pkg::S_SRAM});
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign ACC_DONE   = r.acc_done;
    assign ACC_REGION = r.region;
    assign ACC_EADDR  = r.eaddr;
    assign ACC_RDATA  = r.rdata;
    assign SRAM_CE    = r.sram_ce;
    assign SRAM_WE    = r.sram_we;
    assign PTR_WB     = r.ptr_wb;
    assign CPU_STALL  = r.stall;
    assign GIE        = r.gie;
    assign IRQ_ACK    = r.irq_ack;
    assign PC_LOAD    = r.pc_load;
    assign PC_OUT     = r.pc_out;
    assign STK        = r.stk;
    assign SP         = r.sp;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge SYS_CLK iff CE); endclocking
    default disable iff (!RST_B);

    sequence push_two;
        r.stk.we ##1 r.stk.we ##1 !r.stk.we;
    endsequence
    sequence jump_three;
        r.stall [*3] ##1 !r.stall;
    endsequence

    a_entry_four_cycles: assert property (
        (r.irq_ack && r.fsm == cma_pkg::S_PUSH)
        |-> !r.pc_load [*4] ##1 r.pc_load)
        else $error("vector not loaded four cycles after entry");
    a_entry_push_bytes: assert property (
        (r.irq_ack && r.fsm == cma_pkg::S_PUSH) |-> ##1 push_two)
        else $error("entry push is not two byte writes");
    a_vector_jump_three: assert property (
        (r.pc_load && r.fsm == cma_pkg::S_JUMP) |-> jump_three)
        else $error("vector jump not three cycles");
    a_entry_clears_gie: assert property (
        r.irq_ack |-> !r.gie && $past(r.gie))
        else $error("entry did not clear global enable");
    a_wake_adds_four: assert property (
        (r.fsm == cma_pkg::S_WAKE && WAKE_READY && r.cnt == 4'h0)
        |-> (r.fsm == cma_pkg::S_WAKE) [*4] ##1 r.fsm == cma_pkg::S_PUSH)
        else $error("wake extension not four cycles");
    a_return_four_cycles: assert property (
        (r.fsm == cma_pkg::S_IDLE && RETURN_FROM_INTERRUPT_REQ)
        |=> (r.fsm == cma_pkg::S_RETURN_FROM_INTERRUPT) [*4]
            ##1 (r.pc_load && r.gie && r.sp == $past(r.sp, 5) + 16'h0002))
        else $error("return sequence wrong");
    a_sram_two_cycles: assert property (
        r.sram_ce |-> !r.acc_done ##1 (r.acc_done && !r.sram_ce))
        else $error("sram access not two cycles");
    a_ee_read_stall: assert property (
        r.ee_rd |-> r.stall [*4] ##1 !r.stall)
        else $error("eeprom read stall not four cycles");
    a_ee_write_stall: assert property (
        r.ee_go |-> r.stall [*2] ##1 !r.stall)
        else $error("eeprom write stall not two cycles");
    a_mwe_timeout: assert property (
        $rose(r.mwe) |-> r.mwe [*4] ##1 !r.mwe)
        else $error("master enable window not four cycles");
    a_ee_done_clear: assert property (
        (r.ee_busy && r.ee_tmr == 18'h0_0001) |=> !r.ee_busy)
        else $error("strobe not cleared at write end");
    a_ptr_writeback: assert property (
        r.ptr_wb.en |-> r.acc_done || r.sram_ce)
        else $error("pointer update without an access");

endmodule

// *** sim/cma_stack_model.sv ***
// ************************************************************
// stack ram on the cpu side of the block
// ************************************************************
module cma_stack_model (
    input  wire logic              SYS_CLK,   // cpu clock
    input  wire cma_pkg::cma_stk_t STK,       // stack request
    output logic [7:0]             STK_RDATA  // pop data
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] mem [0:1279];

    initial STK_RDATA = 8'h00;

    // data is only good one cycle after the read; toggle otherwise
    // so a late or early sample can never match by chance
    always @(posedge SYS_CLK) begin
        if (STK.we && STK.addr < 16'h0500)
            mem[STK.addr] <= STK.wdata;
        if (STK.re)
            STK_RDATA <= mem[STK.addr];
        else
            STK_RDATA <= ~STK_RDATA;
    end
endmodule

// *** sim/tb_cma_core.sv ***
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; \
    $display("wrong value t=%0t got %h exp %h", $time, (a), (e)); end end

module tb_cma_core;
    timeunit 1ns;
    timeprecision 1ps;

    logic                sys_clk = 1'b0;
    logic                rst_b = 1'b0;
    logic                req = 1'b0;
    logic                return_from_interrupt = 1'b0;
    logic                irq = 1'b0;
    logic                busy = 1'b0;
    logic                gie_set = 1'b0;
    logic                sleeping = 1'b0;
    logic                wake_rdy = 1'b0;
    logic [12:0]         irq_vec = 13'h0012;
    logic [12:0]         pc_in = 13'h1ABC;
    logic [47:0]         ptrs = 48'h0300_0200_0120;
    cma_pkg::cma_acc_t   cmd = '0;
    logic [7:0]          stk_rd;
    logic                done, sram_ce, sram_we, stall, gie, ack, pc_ld;
    cma_pkg::cma_region_t region;
    logic [15:0]         eaddr, sp;
    logic [7:0]          rdata;
    cma_pkg::cma_ptrwb_t ptr_wb, wb;
    logic [12:0]         pc_out;
    cma_pkg::cma_stk_t   stk;
    int                  fails = 0, n_tests = 0, lat, ce_seen, n;

    cma_core #(.EE_WRITE_CYCLES(20)) i_cma_core (
        .SYS_CLK(sys_clk), .RST_B(rst_b), .CE(1'b1), .ACC_REQ(req),
        .ACC_CMD(cmd), .PTR_FILE(ptrs), .RETURN_FROM_INTERRUPT_REQ(return_from_interrupt), .IRQ_REQ(irq),
        .IRQ_VEC(irq_vec), .INSN_BUSY(busy), .SLEEPING(sleeping),
        .WAKE_READY(wake_rdy), .PC_IN(pc_in), .STK_RDATA(stk_rd),
        .GIE_SET(gie_set), .GIE_CLR(1'b0), .ACC_DONE(done),
        .ACC_REGION(region), .ACC_EADDR(eaddr), .ACC_RDATA(rdata),
        .SRAM_CE(sram_ce), .SRAM_WE(sram_we), .PTR_WB(ptr_wb),
        .CPU_STALL(stall), .GIE(gie), .IRQ_ACK(ack), .PC_LOAD(pc_ld),
        .PC_OUT(pc_out), .STK(stk), .SP(sp));

    cma_stack_model i_cma_stack_model (
        .SYS_CLK(sys_clk), .STK(stk), .STK_RDATA(stk_rd));

    always #12.5 sys_clk = ~sys_clk;

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // ************************************************************
    // bus helpers, entered and left at a falling edge
    // ************************************************************
    task automatic acc(input logic w, input cma_pkg::cma_mode_t m,
            input logic [1:0] p, input logic [5:0] d,
            input logic [15:0] a, input logic [7:0] v);
        cmd = '{w, m, p, d, a, v};
        req = 1'b1;
        wb = '0;
        ce_seen = 0;
        lat = 0;
        do begin
            @(negedge sys_clk);
            req = 1'b0;
            lat++;
            if (sram_ce === 1'b1) ce_seen = 1;
            if (ptr_wb.en === 1'b1) wb = ptr_wb;
        end while (done !== 1'b1 && lat < 20);
        if (done !== 1'b1) begin
            fails++;
            end_sim();
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        acc(1'b1, cma_pkg::M_DIRECT, 2'd0, 6'd0, a, v);
    endtask

    task automatic rd(input logic [15:0] a);
        acc(1'b0, cma_pkg::M_DIRECT, 2'd0, 6'd0, a, 8'h00);
    endtask

    // counts held cycles, starting in the cycle of the answer
    task automatic stalls();
        n = 0;
        while (stall === 1'b1 && n < 40) begin
            n++;
            @(negedge sys_clk);
        end
        if (stall === 1'b1) begin
            fails++;
            end_sim();
        end
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_decode();
        logic [15:0] ad [8] = '{16'h001F, 16'h0020, 16'h005F, 16'h0060,
                                16'h00FF, 16'h0100, 16'h04FF, 16'h0500};
        int ex [8] = '{0, 1, 1, 2, 2, 3, 3, 4};
        `CHK(gie, 1'b0)
        `CHK(sp, 16'h04FF)
        for (int i = 0; i < 8; i++) begin
            rd(ad[i]);
            `CHK(region, cma_pkg::cma_region_t'(ex[i]))
            `CHK(eaddr, ad[i])
            `CHK(lat, (ex[i] == 3) ? 2 : 1)
            `CHK(ce_seen, (ex[i] == 3) ? 1 : 0)
        end
        $display("decode test done");
    endtask

    task automatic t_ptr();
        acc(1'b0, cma_pkg::M_POSTINC, 2'd0, 6'd0, 16'h0000, 8'h00);
        `CHK(eaddr, 16'h0120)
        `CHK(wb, {1'b1, 2'd0, 16'h0121})
        acc(1'b1, cma_pkg::M_PREDEC, 2'd1, 6'd0, 16'h0000, 8'h55);
        `CHK(eaddr, 16'h01FF)
        `CHK(wb, {1'b1, 2'd1, 16'h01FF})
        `CHK(sram_we, 1'b1)
        acc(1'b0, cma_pkg::M_DISP, 2'd2, 6'h3F, 16'h0000, 8'h00);
        `CHK(eaddr, 16'h033F)
        `CHK(wb.en, 1'b0)
        acc(1'b0, cma_pkg::M_IND, 2'd2, 6'd0, 16'h0000, 8'h00);
        `CHK(eaddr, 16'h0300)
        `CHK(wb.en, 1'b0)
        `CHK(sram_we, 1'b0)
        acc(1'b0, cma_pkg::M_IOSHORT, 2'd0, 6'd0, 16'h003F, 8'h00);
        `CHK(eaddr, 16'h005F)
        `CHK(region, cma_pkg::R_IO)
        $display("pointer test done");
    endtask

    task automatic t_ee();
        wr(cma_pkg::EE_ADRL_A, 8'hA5);
        wr(cma_pkg::EE_ADRH_A, 8'h01);
        wr(cma_pkg::EE_DATA_A, 8'h3C);
        `CHK(region, cma_pkg::R_IO)
        wr(cma_pkg::EE_CTRL_A, 8'h04);
        repeat (5) @(negedge sys_clk);
        rd(cma_pkg::EE_CTRL_A);
        `CHK(rdata[2], 1'b0)
        wr(cma_pkg::EE_CTRL_A, 8'h02);
        stalls();
        `CHK(n, 0)
        wr(cma_pkg::EE_CTRL_A, 8'h04);
        wr(cma_pkg::EE_CTRL_A, 8'h02);
        stalls();
        `CHK(n, 2)
        rd(cma_pkg::EE_CTRL_A);
        `CHK(rdata[1], 1'b1)
        for (int i = 0; i < 60 && rdata[1] === 1'b1; i++)
            rd(cma_pkg::EE_CTRL_A);
        `CHK(rdata[1], 1'b0)
        if (rdata[1] !== 1'b0) end_sim();
        wr(cma_pkg::EE_DATA_A, 8'h00);
        wr(cma_pkg::EE_CTRL_A, 8'h01);
        stalls();
        `CHK(n, 4)
        rd(cma_pkg::EE_DATA_A);
        `CHK(rdata, 8'h3C)
        $display("eeprom test done");
    endtask

    task automatic t_irq();
        int ka = 0, kp = 0, ns = 0, nw = 0;
        logic [15:0] wa [2];
        logic [7:0] wd [2];
        gie_set = 1'b1;
        busy = 1'b1;
        irq = 1'b1;
        for (int k = 0; k < 3; k++) begin
            @(negedge sys_clk);
            gie_set = 1'b0;
            if (ack === 1'b1) ka++;
        end
        `CHK(gie, 1'b1)
        `CHK(ka, 0)
        busy = 1'b0;
        for (int k = 1; k < 10; k++) begin
            @(negedge sys_clk);
            if (ack === 1'b1) ka = k;
            if (ack === 1'b1) irq = 1'b0;
            if (pc_ld === 1'b1) kp = k;
            if (stall === 1'b1) ns++;
            if (stk.we === 1'b1 && nw < 2) begin
                wa[nw] = stk.addr;
                wd[nw] = stk.wdata;
                nw++;
            end
        end
        `CHK(ka, 1)
        `CHK(kp, 5)
        `CHK(pc_out, 13'h0012)
        `CHK(ns, 7)
        `CHK(gie, 1'b0)
        `CHK({wa[0], wd[0], wa[1], wd[1]}, 48'h04FF_BC04_FE1A)
        `CHK(sp, 16'h04FD)
        return_from_interrupt = 1'b1;
        kp = 0;
        for (int k = 1; k < 8; k++) begin
            @(negedge sys_clk);
            return_from_interrupt = 1'b0;
            if (pc_ld === 1'b1) kp = k;
        end
        `CHK(kp, 5)
        `CHK(pc_out, 13'h1ABC)
        `CHK(gie, 1'b1)
        `CHK(sp, 16'h04FF)
        $display("interrupt test done");
    endtask

    // start-up takes two cycles here; four more follow it
    task automatic t_wake();
        int ka = 0, kp = 0;
        sleeping = 1'b1;
        irq = 1'b1;
        for (int k = 1; k < 16; k++) begin
            @(negedge sys_clk);
            wake_rdy = (k >= 3);
            if (ack === 1'b1) ka = k;
            if (ack === 1'b1) irq = 1'b0;
            if (ack === 1'b1) sleeping = 1'b0;
            if (pc_ld === 1'b1) kp = k;
        end
        `CHK(ka, 1)
        `CHK(kp, 11)
        `CHK(gie, 1'b0)
        $display("wake test done");
    endtask

    initial begin
        repeat (8) @(negedge sys_clk);
        rst_b = 1'b1;
        @(negedge sys_clk);
        t_decode();
        t_ptr();
        t_ee();
        t_irq();
        t_wake();
        end_sim();
    end
endmodule
